// [hdl/mmd_pkg.sv]
package mmd_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam logic [15:0] VEC_BASE = 16'h0000;
    localparam logic [15:0] VEC_LAST = 16'h0013;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_LVD = 16'h0006;
    localparam logic [15:0] VEC_EXT0 = 16'h0008;
    localparam logic [15:0] VEC_EXT1 = 16'h000A;
    localparam logic [15:0] VEC_TMR8 = 16'h000C;
    localparam logic [15:0] VEC_T16A = 16'h000E;
    localparam logic [15:0] VEC_T16B = 16'h0010;
    localparam logic [15:0] VEC_ADC = 16'h0012;
    localparam logic [15:0] TABLE_CALL_INSTRUCTION_BASE = 16'h0040;
    localparam logic [15:0] TABLE_CALL_INSTRUCTION_LAST = 16'h007F;
    localparam logic [15:0] OPTION_ADDR = 16'h0080;
    localparam logic [15:0] PROTECT_ADDR = 16'h0081;
    localparam logic [15:0] RAM_BASE = 16'hFE80;
    localparam logic [15:0] RAM_LAST = 16'hFEFF;
    localparam logic [15:0] SFR_BASE = 16'hFF00;
    localparam int unsigned RAM_BYTES = 128;
    localparam int unsigned FLASH_DEF = 4096;
    localparam logic [7:0] OPEN_READ = 8'hFF;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        MMD_RUN = 2'b00,
        MMD_VLO = 2'b01,
        MMD_VHI = 2'b11
    } mmd_state_t;

    typedef enum logic [2:0] {
        MMD_RG_NONE = 3'h0,
        MMD_RG_FLASH = 3'h1,
        MMD_RG_RAM = 3'h2,
        MMD_RG_SFR = 3'h3
    } mmd_region_t;

    // irq source index to vector address
    typedef enum logic [2:0] {
        MMD_IRQ_LVD = 3'h0,
        MMD_IRQ_EXT0 = 3'h1,
        MMD_IRQ_EXT1 = 3'h2,
        MMD_IRQ_TMR8 = 3'h3,
        MMD_IRQ_T16A = 3'h4,
        MMD_IRQ_T16B = 3'h5,
        MMD_IRQ_ADC = 3'h6
    } mmd_irq_t;
endpackage

// [hdl/mmd_decoder.sv]
// How it works
// [R1] one flat 64 KB space, 16-bit addresses, for fetch and data alike
// [R2] bytes 0000H..0013H form the vector table for reset and interrupts
// [R3] vector low byte sits at even address, high byte at next odd one
// [R4] reset 0000H, lvd 0006H, ext0 0008H, ext1 000AH, timers 000CH-0010H, adc 0012H
// [R5] 0040H..007FH hold table-call subroutine entry addresses
// [R6] option byte lives at 0080H
// [R7] flash protect byte lives at 0081H
// [R8] flash of 1, 2 or 4 KB from address zero, fetched by program counter
// [R9] 128 bytes fast RAM, also the stack
// [R10] FE80H..FEFFH decode as internal data memory
// [R11] FF00H..FFFFH go to the special function registers, not memory
// [R12] reset pin is active-low system reset, always so at power-on
// [R13] on reset program counter loads from vector at 0000H/0001H
// [R14] unmapped accesses corrupt nothing and read a fixed pattern
`timescale 1ns/100ps
`default_nettype none
module mmd_decoder
    import mmd_pkg::*;
#(
    parameter int unsigned FLASH_BYTES = FLASH_DEF,
    parameter bit HAS_ADC = 1'b1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // cpu access port
    input wire logic [15:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    // vector lookup request from interrupt controller
    input wire logic vec_req_in,
    input wire logic [2:0] vec_src_in,
    output logic [15:0] vec_addr_out,
    output logic vec_valid_out,
    // reset vector load
    output logic [15:0] program_counter_out,
    output logic pc_load_out,
    output logic boot_busy_out,
    // flash programming port
    input wire logic flash_wr_in,
    input wire logic [15:0] flash_waddr_in,
    input wire logic [7:0] flash_wdata_in,
    // sfr window
    output logic sfr_sel_out,
    output logic [7:0] sfr_addr_out,
    output logic sfr_wr_out,
    output logic [7:0] sfr_wdata_out,
    input wire logic [7:0] sfr_rdata_in,
    // region flags, plus option and protect bytes loaded at boot
    output logic [2:0] region_out,
    output logic in_vector_out,
    output logic in_table_call_instruction_out,
    output logic option_byte_out_sel,
    output logic protect_sel_out,
    output logic [7:0] option_byte_out,
    output logic [7:0] protect_byte_out
);
    localparam int unsigned FA_W = $clog2(FLASH_BYTES);
    localparam int unsigned RA_W = $clog2(RAM_BYTES);

    // refuse flash sizes the index slicing cannot serve
    if (FLASH_BYTES != 1024 && FLASH_BYTES != 2048 && FLASH_BYTES != 4096) begin : g_bad_flash
        $error("flash size must be 1024, 2048 or 4096");
    end

    logic [7:0] flash_mem [FLASH_BYTES];
    logic [7:0] ram_mem [RAM_BYTES];

    typedef struct packed {
        mmd_state_t st;
        logic [15:0] pc;
        logic pc_load;
        logic [7:0] rdata;
        logic rvalid;
        logic rd_sfr;
        logic [15:0] vec;
        logic vec_valid;
        logic [7:0] opt;
        logic [7:0] prot;
    } mmd_regs_t;

    mmd_regs_t q_r;
    mmd_regs_t q_nxt;

    function automatic mmd_region_t region_of(input logic [15:0] a);
        if (a >= SFR_BASE) begin
            return MMD_RG_SFR; // R11
        end else if (a >= RAM_BASE && a <= RAM_LAST) begin
            return MMD_RG_RAM; // R10
        end else if (a < 16'(FLASH_BYTES)) begin
            return MMD_RG_FLASH; // R8
        end
        return MMD_RG_NONE;
    endfunction

    function automatic logic [15:0] vec_of(input logic [2:0] s);
        case (s)
            MMD_IRQ_LVD: return VEC_LVD; // R4
            MMD_IRQ_EXT0: return VEC_EXT0;
            MMD_IRQ_EXT1: return VEC_EXT1;
            MMD_IRQ_TMR8: return VEC_TMR8;
            MMD_IRQ_T16A: return VEC_T16A;
            MMD_IRQ_T16B: return VEC_T16B;
            MMD_IRQ_ADC: return HAS_ADC ? VEC_ADC : VEC_RESET;
            default: return VEC_RESET;
        endcase
    endfunction

    function automatic logic [7:0] flash_rd(input logic [15:0] a);
        return flash_mem[a[FA_W-1:0]];
    endfunction

    mmd_region_t acc_rg;
    assign acc_rg = region_of(addr_in); // R1

    always_comb begin
        q_nxt = q_r;
        q_nxt.pc_load = 1'b0;
        q_nxt.rvalid = 1'b0;
        q_nxt.rd_sfr = 1'b0;
        q_nxt.vec_valid = 1'b0;
        case (q_r.st)
            // two cycles: low byte from even, then high byte from odd
            MMD_VLO: begin
                q_nxt.pc[7:0] = flash_rd(VEC_RESET); // R3 R13
                q_nxt.st = MMD_VHI;
            end
            MMD_VHI: begin
                q_nxt.pc[15:8] = flash_rd(VEC_RESET + 16'h0001); // R3 R13
                q_nxt.pc_load = 1'b1;
                q_nxt.opt = flash_rd(OPTION_ADDR); // R6
                q_nxt.prot = flash_rd(PROTECT_ADDR); // R7
                q_nxt.st = MMD_RUN;
            end
            MMD_RUN: begin
                if (rd_in) begin
                    q_nxt.rvalid = 1'b1;
                    case (acc_rg)
                        MMD_RG_FLASH: q_nxt.rdata = flash_rd(addr_in);
                        MMD_RG_RAM: q_nxt.rdata = ram_mem[addr_in[RA_W-1:0]]; // R9
                        MMD_RG_SFR: q_nxt.rd_sfr = 1'b1;
                        default: q_nxt.rdata = OPEN_READ; // R14
                    endcase
                end
                if (vec_req_in) begin
                    q_nxt.vec = vec_of(vec_src_in); // R2
                    q_nxt.vec_valid = 1'b1;
                end
            end
            default: q_nxt.st = MMD_VLO;
        endcase
    end

    // flash is read-only to the cpu; writes come only via the programming port
    always_ff @(posedge clk_in) begin
        if (ce_in && flash_wr_in && flash_waddr_in < 16'(FLASH_BYTES)) begin
            flash_mem[flash_waddr_in[FA_W-1:0]] <= flash_wdata_in; // R8
        end
        if (ce_in && rst_n_in && q_r.st == MMD_RUN && wr_in && acc_rg == MMD_RG_RAM) begin
            ram_mem[addr_in[RA_W-1:0]] <= wdata_in; // R9 R14
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q_r <= '{st: MMD_VLO, pc: ADDR_ZERO, pc_load: 1'b0, rdata: 8'h00, rvalid: 1'b0,
                     rd_sfr: 1'b0, vec: ADDR_ZERO, vec_valid: 1'b0, opt: 8'h00, prot: 8'h00}; // R12
        end else if (ce_in) begin
            q_r <= q_nxt;
        end
    end

    // sfr read data arrives from peripherals one cycle after select
    assign rdata_out = q_r.rd_sfr ? sfr_rdata_in : q_r.rdata;
    assign rvalid_out = q_r.rvalid;
    assign vec_addr_out = q_r.vec;
    assign vec_valid_out = q_r.vec_valid;
    assign program_counter_out = q_r.pc;
    assign pc_load_out = q_r.pc_load;
    assign boot_busy_out = q_r.st != MMD_RUN;
    assign option_byte_out = q_r.opt;
    assign protect_byte_out = q_r.prot;

    assign sfr_sel_out = q_r.st == MMD_RUN && (rd_in || wr_in) && acc_rg == MMD_RG_SFR; // R11
    assign sfr_addr_out = addr_in[7:0];
    assign sfr_wr_out = sfr_sel_out && wr_in;
    assign sfr_wdata_out = wdata_in;
    assign region_out = acc_rg;
    assign in_vector_out = addr_in <= VEC_LAST; // R2
    assign in_table_call_instruction_out = addr_in >= TABLE_CALL_INSTRUCTION_BASE && addr_in <= TABLE_CALL_INSTRUCTION_LAST; // R5
    assign option_byte_out_sel = addr_in == OPTION_ADDR; // R6
    assign protect_sel_out = addr_in == PROTECT_ADDR; // R7
endmodule
`default_nettype wire

// [verification/mmd_sfr_model.sv]
`timescale 1ns/100ps
`default_nettype none
module mmd_sfr_model (
    // peripheral side of the sfr window
    input wire logic clk_in,
    input wire logic sel_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] regs [256];
    always @(posedge clk_in) begin
        if (sel_in && wr_in) regs[addr_in] <= wdata_in;
        // unselected: flip so a stale value never passes for data
        rdata_out <= sel_in ? regs[addr_in] : ~rdata_out;
    end
endmodule
`default_nettype wire

// [verification/mmd_decoder_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module mmd_decoder_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [15:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic vec_req_in,
    input wire logic [2:0] vec_src_in,
    input wire logic rvalid_out,
    input wire logic [15:0] vec_addr_out,
    input wire logic vec_valid_out,
    input wire logic pc_load_out,
    input wire logic boot_busy_out,
    input wire logic sfr_sel_out,
    input wire logic [7:0] sfr_addr_out,
    input wire logic [2:0] region_out,
    input wire logic in_vector_out,
    input wire logic in_table_call_instruction_out,
    input wire logic option_byte_out_sel,
    input wire logic protect_sel_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic go;
    assign go = ce_in && !boot_busy_out;
    sequence s_release; $rose(rst_n_in); endsequence
    sequence s_pc_load; ##[1:4] pc_load_out; endsequence
    property p_boot; s_release |-> s_pc_load; endproperty
    property p_rv; rd_in && !wr_in && go |=> rvalid_out; endproperty
    property p_ram; (addr_in[15:7] == 9'h1FD) == (region_out == 3'h2); endproperty
    property p_sfr; addr_in[15:8] == 8'hFF && rd_in && go |-> sfr_sel_out && sfr_addr_out == addr_in[7:0]; endproperty
    property p_vec; in_vector_out == (addr_in <= 16'h0013); endproperty
    property p_table_call_instruction; in_table_call_instruction_out == (addr_in >= 16'h0040 && addr_in <= 16'h007F); endproperty
    property p_opt; option_byte_out_sel == (addr_in == 16'h0080); endproperty
    property p_prot; protect_sel_out == (addr_in == 16'h0081); endproperty
    property p_vsrc; vec_req_in && go && vec_src_in != 3'h7
        |=> vec_valid_out && vec_addr_out == 16'h0006 + {12'h000, $past(vec_src_in), 1'b0}; endproperty
    a_boot: assert property (p_boot) else $error("no pc load after reset");
    a_rv: assert property (p_rv) else $error("read not answered");
    a_ram: assert property (p_ram) else $error("ram region decode");
    a_sfr: assert property (p_sfr) else $error("sfr select decode");
    a_vec: assert property (p_vec) else $error("vector area decode");
    a_table_call_instruction: assert property (p_table_call_instruction) else $error("call table decode");
    a_opt: assert property (p_opt) else $error("option byte decode");
    a_prot: assert property (p_prot) else $error("protect byte decode");
    a_vsrc: assert property (p_vsrc) else $error("vector address");
endmodule
bind mmd_decoder mmd_decoder_asserts mmd_decoder_asserts_i (.clk_in, .rst_n_in, .ce_in, .addr_in, .rd_in,
    .wr_in, .vec_req_in, .vec_src_in, .rvalid_out, .vec_addr_out, .vec_valid_out, .pc_load_out, .boot_busy_out,
    .sfr_sel_out, .sfr_addr_out, .region_out, .in_vector_out, .in_table_call_instruction_out, .option_byte_out_sel, .protect_sel_out);
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import mmd_pkg::*;
    logic clk_in = 0, rst_n_in = 0, rd = 0, wr = 0, vreq = 0, fwr = 0, rvalid, vvalid, pcl, sel, swr;
    logic ce = 1'b1;
    logic [15:0] addr = '0, faddr = '0, vaddr, pc;
    logic [7:0] wd = '0, fd = '0, q, rdata, sfr_rd, sfr_a, sfr_wd, opt, prot;
    logic [2:0] src = '0;
    int n_errors = 0, checked = 0;
    mmd_decoder #(.FLASH_BYTES(1024)) mmd_decoder_i (.clk_in, .rst_n_in, .ce_in(ce), .addr_in(addr),
        .rd_in(rd), .wr_in(wr), .wdata_in(wd), .rdata_out(rdata), .rvalid_out(rvalid), .vec_req_in(vreq),
        .vec_src_in(src), .vec_addr_out(vaddr), .vec_valid_out(vvalid), .program_counter_out(pc),
        .pc_load_out(pcl), .boot_busy_out(), .flash_wr_in(fwr), .flash_waddr_in(faddr), .flash_wdata_in(fd),
        .sfr_sel_out(sel), .sfr_addr_out(sfr_a), .sfr_wr_out(swr), .sfr_wdata_out(sfr_wd), .sfr_rdata_in(sfr_rd),
        .region_out(), .in_vector_out(), .in_table_call_instruction_out(), .option_byte_out_sel(), .protect_sel_out(),
        .option_byte_out(opt), .protect_byte_out(prot));
    mmd_sfr_model mmd_sfr_model_i (.clk_in, .sel_in(sel), .wr_in(swr), .addr_in(sfr_a), .wdata_in(sfr_wd),
        .rdata_out(sfr_rd));
    initial forever #50 clk_in = ~clk_in;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk_in);
        rd <= 1'b0;
        wr <= 1'b0;
        #1 q = rdata;
        if (!w) chk("rvalid", 16'h0001, {15'h0000, rvalid});
    endtask
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        fwr <= 1'b1;
        faddr <= a;
        fd <= d;
    endtask
    // two-cycle reset, then bounded wait for the vector load
    task automatic boot(input bit c);
        int i;
        @(posedge clk_in);
        fwr <= 1'b0;
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (i = 0; i < 8 && pcl !== 1'b1; i++) @(posedge clk_in) #1;
        if (pcl !== 1'b1) begin
            n_errors++;
            complete_run();
        end
        if (c) chk("pc", 16'h1234, pc);
        if (c) chk("option", 16'h00A5, {8'h00, opt});
        if (c) chk("protect", 16'h005A, {8'h00, prot});
        $display("boot test done");
    endtask
    task automatic t_mem();
        acc(1'b1, 16'hFE80, 8'h3C);
        acc(1'b1, 16'hFEFF, 8'hC3);
        acc(1'b1, 16'h8000, 8'h00);
        acc(1'b1, 16'h0080, 8'h00);
        acc(1'b1, 16'hFF10, 8'h69);
        acc(1'b0, 16'hFE80, 8'h00); chk("ram low", 16'h003C, {8'h00, q});
        acc(1'b0, 16'hFEFF, 8'h00); chk("ram high", 16'h00C3, {8'h00, q});
        acc(1'b0, 16'hFE7F, 8'h00); chk("below ram", 16'h00FF, {8'h00, q});
        acc(1'b0, 16'h8000, 8'h00); chk("open", 16'h00FF, {8'h00, q});
        acc(1'b0, 16'h0400, 8'h00); chk("past flash", 16'h00FF, {8'h00, q});
        acc(1'b0, 16'h0080, 8'h00); chk("option read", 16'h00A5, {8'h00, q});
        acc(1'b0, 16'hFF10, 8'h00); chk("sfr", 16'h0069, {8'h00, q});
        $display("memory test done");
    endtask
    task automatic t_vec();
        int s;
        // source 7 is unassigned and falls back to the reset vector
        for (s = 0; s < 8; s++) begin
            @(posedge clk_in);
            vreq <= 1'b1;
            src <= 3'(s);
            @(posedge clk_in);
            vreq <= 1'b0;
            #1 chk("vector", (s == 7) ? 16'h0000 : 16'h0006 + 16'(2 * s), vaddr);
            chk("vector valid", 16'h0001, {15'h0000, vvalid});
        end
        $display("vector test done");
    endtask
    // enable low must freeze state, so a read gets no answer
    task automatic t_ce();
        @(posedge clk_in);
        ce <= 1'b0;
        rd <= 1'b1;
        addr <= 16'hFE80;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk("frozen rvalid", 16'h0000, {15'h0000, rvalid});
        @(posedge clk_in);
        ce <= 1'b1;
        $display("enable test done");
    endtask
    initial begin
        boot(1'b0);
        prog(16'h0000, 8'h34);
        prog(16'h0001, 8'h12);
        prog(16'h0080, 8'hA5);
        prog(16'h0081, 8'h5A);
        boot(1'b1);
        t_mem();
        t_vec();
        t_ce();
        complete_run();
    end
endmodule
`default_nettype wire
